// file: core/phcp_pkg.sv
// phcp_pkg: constants, register map and carrier types of the header commit-point block
// assumes a 250 MHz core clock and a 32-bit classic wishbone register bus
package phcp_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_TEST     = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    // field positions
    localparam int CTRL_RESET_BIT = 15;
    localparam int TEST_MODE_LSB  = 13;
    localparam int TEST_MODE_W    = 3;
    localparam int STAT_LOC_BIT   = 12;
    localparam int STAT_REM_BIT   = 11;
    localparam int IRQ_W          = 4;

    // interrupt bit positions
    localparam int IRQ_LOC_UP   = 0;
    localparam int IRQ_LOC_DOWN = 1;
    localparam int IRQ_REM_UP   = 2;
    localparam int IRQ_RST_DONE = 3;

    // encodings and reset values
    localparam logic [2:0] TEST_MODE_NORMAL = 3'h0;
    localparam logic [2:0] TEST_MODE_1      = 3'h1;
    localparam logic       HDR_OK           = 1'b1;
    localparam logic       HDR_NOT_OK       = 1'b0;
    localparam logic [3:0] IRQ_MASK_RESET   = 4'h0;

    // timing
    localparam int CLK_PERIOD_NS   = 4;
    localparam int SOFT_RESET_NS   = 1000;
    localparam int SOFT_RESET_CYC  = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_BLOCKS_DEF = 4;
    localparam int LOSS_BLOCKS_DEF = 2;

    // one-cycle indications from the receive block decoder
    typedef struct packed {
        logic hdr_valid;   // header of a received block decoded
        logic hdr_good;    // that header passed its check
        logic hdr_status;  // decoded partner header status field
        logic zero_blk;    // block with zero symbols in pilot and header places
    } phcp_rx_t;

    typedef enum logic [0:0] {
        PHCP_RS_IDLE = 1'b0,
        PHCP_RS_BUSY = 1'b1
    } phcp_rst_state_t;

endpackage : phcp_pkg

// file: core/phcp_lock_track.sv
// phcp_lock_track: local receive header lock from good headers and zero blocks
// assumes one-cycle pulses on core_clk from the block decoder
`timescale 1ns/1ps
module phcp_lock_track #(
    parameter int LOCK_BLOCKS = phcp_pkg::LOCK_BLOCKS_DEF,
    parameter int LOSS_BLOCKS = phcp_pkg::LOSS_BLOCKS_DEF
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic clr,
    input  wire logic hdr_good,
    input  wire logic zero_blk,
    output logic      lock
);
    localparam int CW = $clog2(LOCK_BLOCKS + LOSS_BLOCKS + 1);
    localparam logic [CW-1:0] LOCK_N = CW'(LOCK_BLOCKS);
    localparam logic [CW-1:0] LOSS_N = CW'(LOSS_BLOCKS);

    typedef struct packed {
        logic [CW-1:0] good_cnt;
        logic [CW-1:0] zero_cnt;
        logic          lock;
    } phcp_lt_state_t;

    phcp_lt_state_t s;
    phcp_lt_state_t next_s;

    // refuse counts that could never lock or never lose
    initial begin
        if (LOCK_BLOCKS < 1 || LOSS_BLOCKS < 1) begin
            $error("phcp_lock_track: block counts must be at least one");
        end
    end

    // partner header status is not looked at, so lock comes without it
    always_comb begin
        next_s = s;
        if (clr) begin
            next_s = '0;
        end else if (hdr_good) begin
            next_s.zero_cnt = '0;
            if (s.good_cnt < LOCK_N) begin
                next_s.good_cnt = s.good_cnt + CW'(1);
            end
            if (s.good_cnt + CW'(1) >= LOCK_N) begin
                next_s.lock = 1'b1;
            end
        end else if (zero_blk) begin
            next_s.good_cnt = '0;
            if (s.zero_cnt < LOSS_N) begin
                next_s.zero_cnt = s.zero_cnt + CW'(1);
            end
            if (s.zero_cnt + CW'(1) >= LOSS_N) begin
                next_s.lock = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign lock = s.lock;

endmodule : phcp_lock_track

// file: core/phcp_top.sv
// phcp_top: header commit points, remote lock tracking and register file
// assumes decoder and block builder run on core_clk; wishbone classic slave
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module phcp_top #(
    parameter int LOCK_BLOCKS = phcp_pkg::LOCK_BLOCKS_DEF,
    parameter int LOSS_BLOCKS = phcp_pkg::LOSS_BLOCKS_DEF,
    parameter int RESET_CYC   = phcp_pkg::SOFT_RESET_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    input  wire logic [3:0]        wb_sel_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire phcp_pkg::phcp_rx_t rx,
    input  wire logic              tx_blk_start,
    output logic                   hdr_status_field,
    output logic                   remote_lock,
    output logic                   mii_ignore,
    output logic [2:0]             test_mode,
    output logic                   soft_reset,
    output logic                   irq
);
    localparam int RW = $clog2(RESET_CYC + 1);
    localparam logic [RW-1:0] RESET_N = RW'(RESET_CYC);

    typedef struct packed {
        logic                       ack;
        logic [31:0]                rdata;
        logic                       hdr_tx;
        logic                       rem_lock;
        logic [2:0]                 tmode;
        logic                       ignore;
        phcp_pkg::phcp_rst_state_t  rstate;
        logic [RW-1:0]              rcnt;
        logic                       loc_prev;
        logic [3:0]                 istat;
        logic [3:0]                 imask;
        logic                       irq;
    } phcp_state_t;

    phcp_state_t s;
    phcp_state_t next_s;
    logic        loc_lock;

    // a zero-length reset would never be seen busy by a poller
    initial begin
        if (RESET_CYC < 1) begin
            $error("phcp_top: reset length must be at least one cycle");
        end
    end

    // local lock tracking, cleared while the soft reset runs
    phcp_lock_track #(
        .LOCK_BLOCKS (LOCK_BLOCKS),
        .LOSS_BLOCKS (LOSS_BLOCKS)
    ) u_lock (
        .core_clk (core_clk),
        .rst      (rst),
        .clr      (s.rstate == phcp_pkg::PHCP_RS_BUSY),
        .hdr_good (rx.hdr_valid & rx.hdr_good),
        .zero_blk (rx.zero_blk),
        .lock     (loc_lock)
    );

    // read mux, unmapped offsets read zero
    function automatic logic [31:0] read_reg(input logic [7:0] adr, input phcp_state_t st,
                                             input logic lock);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (adr)
            phcp_pkg::ADDR_CTRL:
                d[phcp_pkg::CTRL_RESET_BIT] = (st.rstate == phcp_pkg::PHCP_RS_BUSY);
            phcp_pkg::ADDR_TEST:
                d[phcp_pkg::TEST_MODE_LSB +: phcp_pkg::TEST_MODE_W] = st.tmode;
            phcp_pkg::ADDR_STATUS: begin
                d[phcp_pkg::STAT_LOC_BIT] = lock;
                d[phcp_pkg::STAT_REM_BIT] = st.rem_lock;
            end
            phcp_pkg::ADDR_IRQ_STAT:
                d[phcp_pkg::IRQ_W-1:0] = st.istat;
            phcp_pkg::ADDR_IRQ_MASK:
                d[phcp_pkg::IRQ_W-1:0] = st.imask;
            default:
                d = 32'h0000_0000;
        endcase
        return d;
    endfunction : read_reg

    always_comb begin
        logic       req;
        logic       wr;
        logic [3:0] ev;
        logic [3:0] w1c;
        req = 1'b0;
        wr  = 1'b0;
        ev  = 4'h0;
        w1c = 4'h0;
        next_s = s;

        // one wait state: answer in the cycle after the request, drop right after
        req = wb_cyc_i & wb_stb_i & ~s.ack;
        wr  = req & wb_we_i;
        next_s.ack = req;
        if (req) begin
            next_s.rdata = read_reg(wb_adr_i, s, loc_lock);
        end

        // test mode survives the soft reset so it can be set up before it
        if (wr && wb_adr_i == phcp_pkg::ADDR_TEST && wb_sel_i[1]) begin
            next_s.tmode = wb_dat_i[phcp_pkg::TEST_MODE_LSB +: phcp_pkg::TEST_MODE_W];
        end
        next_s.ignore = (next_s.tmode == phcp_pkg::TEST_MODE_1);

        // self-clearing soft reset
        unique case (s.rstate)
            phcp_pkg::PHCP_RS_IDLE: begin
                if (wr && wb_adr_i == phcp_pkg::ADDR_CTRL && wb_sel_i[1]
                    && wb_dat_i[phcp_pkg::CTRL_RESET_BIT]) begin
                    next_s.rstate = phcp_pkg::PHCP_RS_BUSY;
                    next_s.rcnt   = RESET_N;
                end
            end
            phcp_pkg::PHCP_RS_BUSY: begin
                next_s.rcnt = s.rcnt - RW'(1);
                if (s.rcnt == RW'(1)) begin
                    next_s.rstate = phcp_pkg::PHCP_RS_IDLE;
                    ev[phcp_pkg::IRQ_RST_DONE] = 1'b1;
                end
            end
        endcase

        // remote lock rises only on a decoded good header with local lock; it clears whenever local lock is lost or the soft reset runs
        if (s.rstate == phcp_pkg::PHCP_RS_BUSY || !loc_lock) begin
            next_s.rem_lock = 1'b0;
        end else if (rx.hdr_valid && rx.hdr_good) begin
            next_s.rem_lock = (rx.hdr_status == phcp_pkg::HDR_OK);
        end

        // outgoing header status committed at each block start, forced to not ok while the soft reset runs
        if (s.rstate == phcp_pkg::PHCP_RS_BUSY) begin
            next_s.hdr_tx = phcp_pkg::HDR_NOT_OK;
        end else if (tx_blk_start) begin
            next_s.hdr_tx = loc_lock;
        end

        // events
        next_s.loc_prev = loc_lock;
        ev[phcp_pkg::IRQ_LOC_UP]   = loc_lock & ~s.loc_prev;
        ev[phcp_pkg::IRQ_LOC_DOWN] = ~loc_lock & s.loc_prev;
        ev[phcp_pkg::IRQ_REM_UP]   = next_s.rem_lock & ~s.rem_lock;

        // sticky status, write one to clear; a new event wins over the clear
        if (wr && wb_adr_i == phcp_pkg::ADDR_IRQ_STAT && wb_sel_i[0]) begin
            w1c = wb_dat_i[phcp_pkg::IRQ_W-1:0];
        end
        next_s.istat = (s.istat & ~w1c) | ev;
        if (wr && wb_adr_i == phcp_pkg::ADDR_IRQ_MASK && wb_sel_i[0]) begin
            next_s.imask = wb_dat_i[phcp_pkg::IRQ_W-1:0];
        end
        next_s.irq = |(next_s.istat & next_s.imask);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s          <= '0;
            s.tmode    <= phcp_pkg::TEST_MODE_NORMAL;
            s.rstate   <= phcp_pkg::PHCP_RS_IDLE;
            s.imask    <= phcp_pkg::IRQ_MASK_RESET;
            s.hdr_tx   <= phcp_pkg::HDR_NOT_OK;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from state flops
    assign wb_ack_o         = s.ack;
    assign wb_dat_o         = s.rdata;
    assign hdr_status_field = s.hdr_tx;
    assign remote_lock      = s.rem_lock;
    assign mii_ignore       = s.ignore;
    assign test_mode        = s.tmode;
    assign soft_reset       = (s.rstate == phcp_pkg::PHCP_RS_BUSY);
    assign irq              = s.irq;

endmodule : phcp_top

// file: bench/phcp_top_asserts.sv
// phcp_top_asserts: port-level checks of phcp_top
// assumes the register map and carrier types of phcp_pkg
`timescale 1ns/1ps
module phcp_top_asserts #(
    parameter int RESET_CYC = 250
) (
    input wire logic               core_clk,
    input wire logic               rst,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [7:0]         wb_adr_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic               wb_ack_o,
    input wire phcp_pkg::phcp_rx_t rx,
    input wire logic               tx_blk_start,
    input wire logic               hdr_status_field,
    input wire logic               remote_lock,
    input wire logic               mii_ignore,
    input wire logic [2:0]         test_mode,
    input wire logic               soft_reset
);
    logic take;
    logic wr_hi;
    int   rst_cnt;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // request taken only while no answer is pending
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_hi = take && wb_we_i && wb_sel_i[1];
    // cycles spent in the self-clearing reset
    always_ff @(posedge core_clk) begin
        if (rst || !soft_reset) begin
            rst_cnt <= 0;
        end else begin
            rst_cnt <= rst_cnt + 1;
        end
    end
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_answer: assert property (take |=> wb_ack_o) else $error("ack missing");
    a_mode_ignore: assert property (mii_ignore == (test_mode == phcp_pkg::TEST_MODE_1))
        else $error("mii ignore wrong");
    a_mode_write: assert property (wr_hi && wb_adr_i == phcp_pkg::ADDR_TEST ##2 1
        |-> test_mode == $past(wb_dat_i[15:13], 2)) else $error("test mode lost");
    a_reset_start: assert property (wr_hi && wb_adr_i == phcp_pkg::ADDR_CTRL
        && wb_dat_i[15] && !soft_reset |-> ##[1:2] soft_reset) else $error("no reset");
    a_reset_ends: assert property (soft_reset |-> rst_cnt < RESET_CYC)
        else $error("reset never clears");
    a_reset_length: assert property ($fell(soft_reset) |-> rst_cnt == RESET_CYC)
        else $error("reset length wrong");
    a_hdr_commit: assert property ($changed(hdr_status_field)
        |-> $past(tx_blk_start) || soft_reset || $past(soft_reset)) else $error("mid-block");
    a_remote_cause: assert property ($rose(remote_lock)
        |-> $past(rx.hdr_valid && rx.hdr_good && rx.hdr_status)) else $error("early");
    c_loc_pub: cover property ($rose(hdr_status_field));
    c_rem_up: cover property ($rose(remote_lock));
    c_rst_done: cover property ($fell(soft_reset));
endmodule : phcp_top_asserts

bind phcp_top phcp_top_asserts #(.RESET_CYC(RESET_CYC)) u_phcp_top_asserts (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .rx(rx), .tx_blk_start(tx_blk_start),
    .hdr_status_field(hdr_status_field), .remote_lock(remote_lock),
    .mii_ignore(mii_ignore), .test_mode(test_mode), .soft_reset(soft_reset));

// file: bench/phcp_partner.sv
// phcp_partner: partner block stream as seen after the block decoder
// assumes one block per 8 cycles, far shorter than on the wire
`timescale 1ns/1ps
module phcp_partner (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic [1:0]    mode,
    output phcp_pkg::phcp_rx_t rx,
    output logic               tx_blk_start
);
    logic [2:0] phase;
    // mode 0 silent, 1 status not ok, 2 status ok, 3 zero blocks
    always_ff @(posedge core_clk) begin
        phase <= rst ? 3'h0 : phase + 3'h1;
        // one assignment per edge, so the pulse never gets two drivers in a step
        if (phase == 3'h0 && mode != 2'h0) begin
            rx <= '{hdr_valid: mode != 2'h3, hdr_good: mode != 2'h3,
                    hdr_status: mode == 2'h2, zero_blk: mode == 2'h3};
        end else begin
            rx <= '0;
        end
        tx_blk_start <= phase == 3'h4;  // offset so lock lands mid-block
    end
endmodule : phcp_partner

// file: bench/phcp_bench.sv
// phcp_bench: register-level tests of phcp_top
// assumes phcp_partner supplies decoder pulses and block starts
`timescale 1ns/1ps
module phcp_bench;
    logic               core_clk = 1'b0;
    logic               rst = 1'b1;
    logic               wb_cyc = 1'b0;
    logic               wb_stb = 1'b0;
    logic               wb_we = 1'b0;
    logic [7:0]         wb_adr = 8'h00;
    logic [31:0]        wb_dat = 32'h0;
    logic [3:0]         wb_sel = 4'h0;
    logic [1:0]         mode = 2'h0;
    logic [31:0]        dat_o, rd_dat;
    logic [2:0]         tmode, outs;
    logic               wb_ack, hdr_fld, rem_lock, mii_ign, soft_rst, irq, tx_blk;
    phcp_pkg::phcp_rx_t rx;
    int                 num_errors = 0;
    int                 cmp_count = 0;
    int                 cycles = 0;
    phcp_top #(.RESET_CYC(20)) u_phcp_top (
        .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
        .wb_dat_o(dat_o), .wb_ack_o(wb_ack), .rx(rx), .tx_blk_start(tx_blk),
        .hdr_status_field(hdr_fld), .remote_lock(rem_lock), .mii_ignore(mii_ign),
        .test_mode(tmode), .soft_reset(soft_rst), .irq(irq));
    phcp_partner u_phcp_partner (
        .core_clk(core_clk), .rst(rst), .mode(mode), .rx(rx), .tx_blk_start(tx_blk));
    assign outs = {irq, rem_lock, hdr_fld};
    always #2 core_clk = ~core_clk;
    // hang guard, well above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        cmp_count++;
        if (act !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, act, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic act, input logic exp);
        chk({31'h0, act}, {31'h0, exp});
    endtask : chk_bit
    // one classic cycle, held until ack is sampled
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= 4'hF;
        do @(posedge core_clk); while (wb_ack !== 1'b1);
        rd_dat = dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : xfer
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        for (int n = 0; n < 100; n++) begin
            xfer(a, 1'b0, 32'h0);
            if ((rd_dat & m) === e) break;
        end
        chk(rd_dat & m, e);
    endtask : poll
    task automatic wait_bit(input int k, input logic v);
        for (int n = 0; n < 40 && outs[k] !== v; n++) @(posedge core_clk);
        chk_bit(outs[k], v);
    endtask : wait_bit
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        poll(phcp_pkg::ADDR_IRQ_MASK, 32'hF, 32'h0);
        poll(8'h1C, 32'hFFFFFFFF, 32'h0);  // unmapped reads zero
        xfer(phcp_pkg::ADDR_TEST, 1'b1, 32'h2000);
        poll(phcp_pkg::ADDR_TEST, 32'hE000, 32'h2000);
        chk_bit(mii_ign, 1'b1);
        chk({29'h0, tmode}, {29'h0, phcp_pkg::TEST_MODE_1});
        xfer(phcp_pkg::ADDR_CTRL, 1'b1, 32'h8000);
        xfer(phcp_pkg::ADDR_CTRL, 1'b0, 32'h0);
        chk(rd_dat & 32'h8000, 32'h8000);
        chk_bit(soft_rst, 1'b1);
        poll(phcp_pkg::ADDR_CTRL, 32'h8000, 32'h0);
        chk_bit(soft_rst, 1'b0);
        xfer(phcp_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0);
        chk(rd_dat & 32'h8, 32'h8);
        $display("test registers and reset done");
        mode <= 2'h1;
        poll(phcp_pkg::ADDR_STATUS, 32'h1000, 32'h1000);
        chk(rd_dat & 32'h0800, 32'h0);
        wait_bit(0, 1'b1);
        $display("test local lock done");
        xfer(phcp_pkg::ADDR_IRQ_MASK, 1'b1, 32'h2);
        mode <= 2'h2;
        wait_bit(1, 1'b1);
        poll(phcp_pkg::ADDR_STATUS, 32'h0800, 32'h0800);
        chk_bit(irq, 1'b0);  // rise events stay masked
        $display("test remote lock done");
        mode <= 2'h3;
        poll(phcp_pkg::ADDR_STATUS, 32'h1000, 32'h0);
        wait_bit(0, 1'b0);
        chk_bit(rem_lock, 1'b0);
        wait_bit(2, 1'b1);
        xfer(phcp_pkg::ADDR_IRQ_STAT, 1'b1, 32'h2);
        wait_bit(2, 1'b0);
        $display("test lock loss done");
        end_sim();
    end
endmodule : phcp_bench
